/* logic/bbb_pkg.sv */
// Purpose: shared constants and types of the byte/bit/branch executor
// Assumes: 32-bit classic wishbone, 14-bit instruction words
// Notes:   byte offsets of the register map are word aligned
package bbb_pkg;

    localparam int DATA_W    = 8;
    localparam int PC_W      = 13;
    localparam int INSTR_W   = 14;
    localparam int FILE_AW   = 7;
    localparam int UPPER_W   = 5;
    localparam int WB_AW     = 8;
    localparam int FILE_DEPTH = 128;

    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_ACCUM     = 8'h08;
    localparam logic [7:0] OFF_PC        = 8'h0c;
    localparam logic [7:0] OFF_UPPER     = 8'h10;
    localparam logic [7:0] OFF_FILE_ADDR = 8'h14;
    localparam logic [7:0] OFF_FILE_DATA = 8'h18;

    localparam int CTRL_RUN    = 0;
    localparam int ST_CARRY    = 0;
    localparam int ST_NIBBLE   = 1;
    localparam int ST_ZERO     = 2;
    localparam int ST_PHASE_LO = 4;
    localparam int ST_FLUSH    = 6;

    localparam logic [7:0]  ACCUM_RST = 8'h00;
    localparam logic [12:0] PC_RST    = 13'h0000;
    localparam logic [4:0]  UPPER_RST = 5'h00;
    localparam logic [6:0]  FADDR_RST = 7'h00;

    localparam logic [1:0] CLS_BYTE  = 2'b00;
    localparam logic [1:0] CLS_BIT   = 2'b01;
    localparam logic [1:0] CLS_JUMP  = 2'b10;
    localparam logic [1:0] CLS_LIT   = 2'b11;
    localparam logic [3:0] OPC_ADD   = 4'h7;
    localparam logic [3:0] OPC_INC   = 4'ha;
    localparam logic [3:0] OPC_AND   = 4'h9;
    localparam logic [1:0] BOP_CLR   = 2'b00;
    localparam logic [1:0] BOP_SET   = 2'b01;
    localparam logic [1:0] BOP_TST   = 2'b10;

    typedef enum logic [1:0] {
        BBB_Q1 = 2'b00,
        BBB_Q2 = 2'b01,
        BBB_Q3 = 2'b10,
        BBB_Q4 = 2'b11
    } bbb_phase_e;

    typedef enum logic [2:0] {
        BBB_OP_NOP = 3'b000,
        BBB_OP_ADD = 3'b001,
        BBB_OP_AND = 3'b010,
        BBB_OP_CLR = 3'b011,
        BBB_OP_SET = 3'b100,
        BBB_OP_TST = 3'b101,
        BBB_OP_JMP = 3'b110,
        BBB_OP_INC = 3'b111
    } bbb_op_e;

endpackage : bbb_pkg

/* logic/bbb_mem_if.sv */
// Purpose: port between executor and its data register file
// Assumes: one shared read/write address, registered read data
// Notes:   none
`timescale 1ns/100ps
interface bbb_mem_if;
    logic [6:0] addr;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport core (output addr, output we, output wdata, input rdata);
    modport mem  (input addr, input we, input wdata, output rdata);
endinterface : bbb_mem_if

/* logic/bbb_regfile.sv */
// Purpose: 128 x 8 data register file
// Assumes: read data registered, old data returned on a write cycle
// Notes:   contents are not reset
`timescale 1ns/100ps
module bbb_regfile (
    input  wire logic clk_i,
    bbb_mem_if.mem    port
);
    logic [7:0] store [bbb_pkg::FILE_DEPTH];

    always_ff @(posedge clk_i) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
        port.rdata <= store[port.addr];
    end
endmodule : bbb_regfile

/* logic/bbb_alu.sv */
// Purpose: data path for add, increment, and, bit clear/set/test
// Assumes: purely combinational
// Notes:   flags are computed for every operation, caller picks
`timescale 1ns/100ps
module bbb_alu (
    input  wire bbb_pkg::bbb_op_e op_i,
    input  wire logic [7:0]       accum_i,
    input  wire logic [7:0]       operand_i,
    input  wire logic [7:0]       literal_i,
    input  wire logic [2:0]       bit_i,
    output logic [7:0]            result_o,
    output logic                  carry_o,
    output logic                  nibble_o,
    output logic                  zero_o,
    output logic                  bit_val_o
);
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] mask;

    assign sum9 = {1'b0, accum_i} + {1'b0, operand_i};
    assign nib5 = {1'b0, accum_i[3:0]} + {1'b0, operand_i[3:0]};
    assign mask = 8'h01 << bit_i;

    always_comb begin
        case (op_i)
            bbb_pkg::BBB_OP_ADD: result_o = sum9[7:0];
            bbb_pkg::BBB_OP_INC: result_o = operand_i + 8'h01;
            bbb_pkg::BBB_OP_AND: result_o = accum_i & literal_i;
            bbb_pkg::BBB_OP_CLR: result_o = operand_i & ~mask;
            bbb_pkg::BBB_OP_SET: result_o = operand_i | mask;
            default:             result_o = operand_i;
        endcase
    end

    assign carry_o   = sum9[8];
    assign nibble_o  = nib5[4];
    assign zero_o    = (result_o == 8'h00);
    assign bit_val_o = |(operand_i & mask);
endmodule : bbb_alu

/* logic/bbb_exec.sv */
// Purpose: four-phase executor for byte, bit and jump instructions
// Assumes: program memory answers prog_addr_o within the Q4->Q1 cycle
// Notes:   bus may touch core state only while halted at Q1
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module bbb_exec (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [12:0]      prog_addr_o,
    input  wire logic [13:0] prog_data_i
);
    bbb_pkg::bbb_phase_e phase;
    bbb_pkg::bbb_op_e    op;
    logic [13:0]         ir;
    logic                flush;
    logic                flush_hold;
    logic                run;
    logic [7:0]          accum;
    logic                carry;
    logic                nibble;
    logic                zero;
    logic [12:0]         pc;
    logic [4:0]          upper;
    logic [6:0]          file_addr;
    logic [7:0]          res_q;
    logic                c_q;
    logic                dc_q;
    logic                z_q;
    logic                bit_q;
    logic [7:0]          opnd_q;
    logic [7:0]          alu_res;
    logic                alu_c;
    logic                alu_dc;
    logic                alu_z;
    logic                alu_bit;
    logic                exec;
    logic                halted;
    logic                in_q4;
    logic                dest_file;
    logic                file_wr;
    logic                wb_req;
    logic                bus_wr;
    logic [31:0]         rd_word;

    bbb_mem_if mem ();

    bbb_regfile u_file (
        .clk_i (clk_i),
        .port  (mem.mem)
    );

    bbb_alu u_alu (
        .op_i      (op),
        .accum_i   (accum),
        .operand_i (mem.rdata),
        .literal_i (ir[7:0]),
        .bit_i     (ir[9:7]),
        .result_o  (alu_res),
        .carry_o   (alu_c),
        .nibble_o  (alu_dc),
        .zero_o    (alu_z),
        .bit_val_o (alu_bit)
    );

    function automatic bbb_pkg::bbb_op_e decode(input logic [13:0] w);
        bbb_pkg::bbb_op_e o;
        o = bbb_pkg::BBB_OP_NOP;
        case (w[13:12])
            bbb_pkg::CLS_BYTE: begin
                if (w[11:8] == bbb_pkg::OPC_ADD) o = bbb_pkg::BBB_OP_ADD;
                if (w[11:8] == bbb_pkg::OPC_INC) o = bbb_pkg::BBB_OP_INC;
            end
            bbb_pkg::CLS_BIT: begin
                if (w[11:10] == bbb_pkg::BOP_CLR) o = bbb_pkg::BBB_OP_CLR;
                if (w[11:10] == bbb_pkg::BOP_SET) o = bbb_pkg::BBB_OP_SET;
                if (w[11:10] == bbb_pkg::BOP_TST) o = bbb_pkg::BBB_OP_TST;
            end
            bbb_pkg::CLS_JUMP: begin
                if (w[11]) o = bbb_pkg::BBB_OP_JMP;
            end
            bbb_pkg::CLS_LIT: begin
                if (w[11:8] == bbb_pkg::OPC_AND) o = bbb_pkg::BBB_OP_AND;
            end
            default: o = bbb_pkg::BBB_OP_NOP;
        endcase
        return o;
    endfunction : decode

    assign exec      = !flush;
    assign in_q4     = (phase == bbb_pkg::BBB_Q4);
    // a pending nop cycle is part of the instruction, so no halt inside it
    assign halted    = !run && !flush && (phase == bbb_pkg::BBB_Q1);
    assign dest_file = ir[7];
    assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr    = wb_req && wb_we_i;

    // which results go back to the file
    assign file_wr = ((op == bbb_pkg::BBB_OP_ADD || op == bbb_pkg::BBB_OP_INC)
                      && dest_file)
                     || op == bbb_pkg::BBB_OP_CLR
                     || op == bbb_pkg::BBB_OP_SET;

    assign mem.addr  = halted ? file_addr : ir[6:0];
    assign mem.wdata = halted ? wb_dat_i[7:0] : res_q;
    assign mem.we    = (in_q4 && exec && file_wr)
                       || (halted && bus_wr && wb_sel_i[0]
                           && wb_adr_i == bbb_pkg::OFF_FILE_DATA);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= bbb_pkg::BBB_Q1;
        end else begin
            case (phase)
                bbb_pkg::BBB_Q1: if (run || flush) phase <= bbb_pkg::BBB_Q2;
                bbb_pkg::BBB_Q2: phase <= bbb_pkg::BBB_Q3;
                bbb_pkg::BBB_Q3: phase <= bbb_pkg::BBB_Q4;
                bbb_pkg::BBB_Q4: phase <= bbb_pkg::BBB_Q1;
                default:         phase <= bbb_pkg::BBB_Q1;
            endcase
        end
    end

    // q1: fetch and decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir <= 14'h0000;
            op <= bbb_pkg::BBB_OP_NOP;
        end else if (phase == bbb_pkg::BBB_Q1 && run) begin
            ir <= prog_data_i;
            op <= decode(prog_data_i);
        end
    end

    // q3: process data, operand arrived in q3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_q  <= 8'h00;
            c_q    <= 1'b0;
            dc_q   <= 1'b0;
            z_q    <= 1'b0;
            bit_q  <= 1'b0;
            opnd_q <= 8'h00;
        end else if (phase == bbb_pkg::BBB_Q3) begin
            res_q  <= alu_res;
            c_q    <= alu_c;
            dc_q   <= alu_dc;
            z_q    <= alu_z;
            bit_q  <= alu_bit;
            opnd_q <= mem.rdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accum <= bbb_pkg::ACCUM_RST;
        end else if (in_q4 && exec && !file_wr
                     && (op == bbb_pkg::BBB_OP_ADD
                         || op == bbb_pkg::BBB_OP_INC
                         || op == bbb_pkg::BBB_OP_AND)) begin
            accum <= res_q;
        end else if (halted && bus_wr && wb_sel_i[0]
                     && wb_adr_i == bbb_pkg::OFF_ACCUM) begin
            accum <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry  <= 1'b0;
            nibble <= 1'b0;
            zero   <= 1'b0;
        end else if (in_q4 && exec) begin
            case (op)
                bbb_pkg::BBB_OP_ADD: begin
                    carry  <= c_q;
                    nibble <= dc_q;
                    zero   <= z_q;
                end
                bbb_pkg::BBB_OP_INC: zero <= z_q;
                bbb_pkg::BBB_OP_AND: zero <= z_q;
                default: ; // flags kept
            endcase
        end else if (halted && bus_wr && wb_sel_i[0]
                     && wb_adr_i == bbb_pkg::OFF_STATUS) begin
            carry  <= wb_dat_i[bbb_pkg::ST_CARRY];
            nibble <= wb_dat_i[bbb_pkg::ST_NIBBLE];
            zero   <= wb_dat_i[bbb_pkg::ST_ZERO];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= bbb_pkg::PC_RST;
        end else if (in_q4) begin
            if (flush) begin
                // skip steps over, jump holds its target
                pc <= flush_hold ? pc : pc + 13'h0001;
            end else if (op == bbb_pkg::BBB_OP_JMP) begin
                pc <= {upper[4:3], ir[10:0]};
            end else begin
                pc <= pc + 13'h0001;
            end
        end else if (halted && bus_wr && wb_adr_i == bbb_pkg::OFF_PC) begin
            if (wb_sel_i[0]) pc[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) pc[12:8] <= wb_dat_i[12:8];
        end
    end

    assign prog_addr_o = pc;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flush      <= 1'b0;
            flush_hold <= 1'b0;
        end else if (in_q4) begin
            if (flush) begin
                flush <= 1'b0;
            end else if (op == bbb_pkg::BBB_OP_JMP) begin
                flush      <= 1'b1;
                flush_hold <= 1'b1;
            end else if (op == bbb_pkg::BBB_OP_TST && !bit_q) begin
                flush      <= 1'b1;
                flush_hold <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run       <= 1'b0;
            upper     <= bbb_pkg::UPPER_RST;
            file_addr <= bbb_pkg::FADDR_RST;
        end else if (bus_wr && wb_sel_i[0]) begin
            if (wb_adr_i == bbb_pkg::OFF_CTRL) run <= wb_dat_i[bbb_pkg::CTRL_RUN];
            if (wb_adr_i == bbb_pkg::OFF_FILE_ADDR) file_addr <= wb_dat_i[6:0];
            if (halted && wb_adr_i == bbb_pkg::OFF_UPPER) upper <= wb_dat_i[4:0];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i)
            bbb_pkg::OFF_CTRL:      rd_word[bbb_pkg::CTRL_RUN] = run;
            bbb_pkg::OFF_STATUS: begin
                rd_word[bbb_pkg::ST_CARRY]  = carry;
                rd_word[bbb_pkg::ST_NIBBLE] = nibble;
                rd_word[bbb_pkg::ST_ZERO]   = zero;
                rd_word[bbb_pkg::ST_PHASE_LO +: 2] = phase;
                rd_word[bbb_pkg::ST_FLUSH]  = flush;
            end
            bbb_pkg::OFF_ACCUM:     rd_word[7:0]  = accum;
            bbb_pkg::OFF_PC:        rd_word[12:0] = pc;
            bbb_pkg::OFF_UPPER:     rd_word[4:0]  = upper;
            bbb_pkg::OFF_FILE_ADDR: rd_word[6:0]  = file_addr;
            bbb_pkg::OFF_FILE_DATA: rd_word[7:0]  = mem.rdata;
            default:                rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) wb_dat_o <= rd_word;
        end
    end

    // checking helpers
    logic [8:0]  add_sum9;
    logic [4:0]  add_nib5;
    logic        add_c_ref;
    logic        add_dc_ref;
    logic [7:0]  add_ref;
    logic [7:0]  and_ref;
    logic [7:0]  inc_ref;
    logic [7:0]  bit_mask;
    logic [12:0] jmp_ref;
    logic        q4_exec;

    assign add_sum9   = {1'b0, accum} + {1'b0, opnd_q};
    assign add_nib5   = {1'b0, accum[3:0]} + {1'b0, opnd_q[3:0]};
    assign add_c_ref  = add_sum9[8];
    assign add_dc_ref = add_nib5[4];
    assign add_ref    = add_sum9[7:0];
    assign and_ref    = accum & ir[7:0];
    assign inc_ref    = opnd_q + 8'h01;
    assign bit_mask   = 8'h01 << ir[9:7];
    assign jmp_ref    = {upper[4:3], ir[10:0]};
    assign q4_exec    = in_q4 && exec;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_phase_walk;
        phase == bbb_pkg::BBB_Q2 ##1 phase == bbb_pkg::BBB_Q3
        ##1 phase == bbb_pkg::BBB_Q4 ##1 phase == bbb_pkg::BBB_Q1;
    endsequence
    sequence s_nop_cycle;
        (flush && !mem.we) [*4];
    endsequence

    property p_phase_walk;
        (phase == bbb_pkg::BBB_Q1 && run) |=> s_phase_walk;
    endproperty
    a_phase_walk: assert property (p_phase_walk)
        else $error("phase order broken");

    property p_add_accum;
        (q4_exec && op == bbb_pkg::BBB_OP_ADD && !dest_file) |=>
            accum == $past(add_ref) && carry == $past(add_c_ref)
            && nibble == $past(add_dc_ref) && zero == ($past(add_ref) == 8'h00);
    endproperty
    a_add_accum: assert property (p_add_accum)
        else $error("add to accumulator wrong");

    property p_add_file;
        (q4_exec && op == bbb_pkg::BBB_OP_ADD && dest_file) |->
            mem.we && mem.wdata == add_ref ##1 $stable(accum)
            && carry == $past(add_c_ref) && nibble == $past(add_dc_ref);
    endproperty
    a_add_file: assert property (p_add_file)
        else $error("add to register wrong");

    property p_and_lit;
        (q4_exec && op == bbb_pkg::BBB_OP_AND) |=> accum == $past(and_ref)
            && $stable(carry) && $stable(nibble)
            && zero == ($past(and_ref) == 8'h00);
    endproperty
    a_and_lit: assert property (p_and_lit)
        else $error("literal and wrong");

    property p_bit_clr;
        (q4_exec && op == bbb_pkg::BBB_OP_CLR) |->
            mem.we && mem.wdata == (opnd_q & ~bit_mask)
            ##1 $stable(zero) && $stable(carry);
    endproperty
    a_bit_clr: assert property (p_bit_clr)
        else $error("bit clear wrong");

    property p_bit_set;
        (q4_exec && op == bbb_pkg::BBB_OP_SET) |->
            mem.we && mem.wdata == (opnd_q | bit_mask)
            ##1 $stable(zero) && $stable(nibble);
    endproperty
    a_bit_set: assert property (p_bit_set)
        else $error("bit set wrong");

    property p_skip;
        (q4_exec && op == bbb_pkg::BBB_OP_TST && (opnd_q & bit_mask) == 8'h00)
            |=> s_nop_cycle ##1 !flush;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip not taken as one nop cycle");

    property p_no_skip;
        (q4_exec && op == bbb_pkg::BBB_OP_TST && (opnd_q & bit_mask) != 8'h00)
            |=> !flush;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("skip taken on a set bit");

    property p_jump_pc;
        (q4_exec && op == bbb_pkg::BBB_OP_JMP) |=> pc == $past(jmp_ref);
    endproperty
    a_jump_pc: assert property (p_jump_pc)
        else $error("jump target wrong");

    property p_jump_nop;
        (q4_exec && op == bbb_pkg::BBB_OP_JMP) |=>
            s_nop_cycle ##1 (!flush && pc == $past(pc, 4));
    endproperty
    a_jump_nop: assert property (p_jump_nop)
        else $error("jump second cycle not idle");

    property p_inc;
        (q4_exec && op == bbb_pkg::BBB_OP_INC && !dest_file) |=>
            accum == $past(inc_ref) && zero == ($past(inc_ref) == 8'h00)
            && $stable(carry);
    endproperty
    a_inc: assert property (p_inc)
        else $error("increment wrong");

endmodule : bbb_exec

/* verification/bbb_prog_mem.sv */
// Purpose: program memory partner feeding instruction words
// Assumes: combinational read, settled well before the Q1 edge
// Notes:   unloaded words read as zero, which decodes as a no-op
`timescale 1ns/100ps
module bbb_prog_mem (
    input  wire logic [12:0] addr_i,
    output logic [13:0]      data_o
);
    logic [13:0] mem [0:8191];

    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 14'h0000;
        end
    end

    assign data_o = mem[addr_i];

    task automatic load(input logic [12:0] a, input logic [13:0] d);
        mem[a] = d;
    endtask : load
endmodule : bbb_prog_mem

/* verification/byte_bit_branch_instr_exec_test.sv */
// Purpose: self-checking bench for the byte/bit/branch executor
// Assumes: classic wishbone master, one program run then halt
// Notes:   end state of the register file, accumulator, status and pc shows every instruction
`timescale 1ns/100ps
module byte_bit_branch_instr_exec_test;
    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    logic        cyc        = 1'b0;
    logic        stb        = 1'b0;
    logic        we         = 1'b0;
    logic [7:0]  adr        = 8'h00;
    logic [3:0]  sel        = 4'h0;
    logic [31:0] wdat       = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [12:0] pc;
    logic [13:0] instr;
    logic [31:0] q;
    int          fail_count = 0;
    int          checks     = 0;
    logic [12:0] p_adr [14] = '{13'h000, 13'h001, 13'h002, 13'h003,
        13'h004, 13'h005, 13'h006, 13'h007, 13'h008, 13'h009, 13'h00a,
        13'h00b, 13'h00c, 13'h1a05};
    logic [13:0] p_wrd [14] = '{14'h07a1, 14'h0721, 14'h0aa2, 14'h0a23,
        14'h393c, 14'h13a0, 14'h15a0, 14'h1a20, 14'h0aa4, 14'h1b20,
        14'h0aa4, 14'h2a05, 14'h0aa4, 14'h2a05};
    logic [7:0]  f_adr [5]  = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
    logic [7:0]  f_ini [5]  = '{8'hc7, 8'h0f, 8'hff, 8'h05, 8'hff};
    logic [7:0]  f_exp [5]  = '{8'h4f, 8'hc9, 8'h00, 8'h05, 8'h00};
    logic [7:0]  rst_off [7] = '{bbb_pkg::OFF_CTRL, bbb_pkg::OFF_STATUS,
        bbb_pkg::OFF_ACCUM, bbb_pkg::OFF_PC, bbb_pkg::OFF_UPPER,
        bbb_pkg::OFF_FILE_ADDR, 8'h1c};

    always #2 clk_i = ~clk_i;

    bbb_exec dut (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .wb_cyc_i    (cyc),
        .wb_stb_i    (stb),
        .wb_we_i     (we),
        .wb_adr_i    (adr),
        .wb_sel_i    (sel),
        .wb_dat_i    (wdat),
        .wb_dat_o    (rdat),
        .wb_ack_o    (ack),
        .prog_addr_o (pc),
        .prog_data_i (instr)
    );

    bbb_prog_mem prog (
        .addr_i (pc),
        .data_o (instr)
    );

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        for (int i = 0; i < 14; i++) begin
            prog.load(p_adr[i], p_wrd[i]);
        end
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, unmapped offset reads zero
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, rst_off[i], 32'h0);
            check(q, 32'h0);
        end
        xfer(1'b1, bbb_pkg::OFF_ACCUM, 32'hba);
        xfer(1'b1, bbb_pkg::OFF_UPPER, 32'h18);
        xfer(1'b0, bbb_pkg::OFF_UPPER, 32'h0);
        check(q, 32'h18);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, bbb_pkg::OFF_FILE_ADDR, {24'h0, f_adr[i]});
            xfer(1'b1, bbb_pkg::OFF_FILE_DATA, {24'h0, f_ini[i]});
        end
        xfer(1'b1, bbb_pkg::OFF_CTRL, 32'h1);
        // accumulator write while running must be dropped
        xfer(1'b1, bbb_pkg::OFF_ACCUM, 32'haa);
        repeat (150) @(posedge clk_i);
        xfer(1'b1, bbb_pkg::OFF_CTRL, 32'h0);
        repeat (12) @(posedge clk_i);
        xfer(1'b0, bbb_pkg::OFF_ACCUM, 32'h0);
        check(q, 32'h04);
        xfer(1'b0, bbb_pkg::OFF_STATUS, 32'h0);
        check(q & 32'h7, 32'h7);
        xfer(1'b0, bbb_pkg::OFF_PC, 32'h0);
        check(q, 32'h1a05);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, bbb_pkg::OFF_FILE_ADDR, {24'h0, f_adr[i]});
            xfer(1'b0, bbb_pkg::OFF_FILE_DATA, 32'h0);
            check(q, {24'h0, f_exp[i]});
        end
        close_out();
    end
endmodule : byte_bit_branch_instr_exec_test
